//--- gpio_port_pkg.sv
// Shared constants and carriers for the eight-bit general-purpose port
package gpio_port_pkg;
  localparam int unsigned DataWidth   = 32;
  localparam int unsigned AddrWidth   = 12;
  localparam int unsigned PortWidth   = 8;
  localparam int unsigned CfgWidth    = 4;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  PinDataIdx  = 8'h05;
  localparam logic [7:0]  DirIdx      = 8'h85;
  localparam logic [7:0]  AnaCfgIdx   = 8'h9f;
  // Reset values
  localparam logic [7:0]  DirReset    = 8'hff;
  localparam logic [7:0]  LatchReset  = 8'h00;
  localparam logic [7:0]  AnaCfgReset = 8'h00;
  // Field positions and masks
  localparam int unsigned InputOnlyBit  = 5;
  localparam int unsigned TimerClkBit   = 4;
  localparam int unsigned ClkOutBit     = 6;
  localparam int unsigned OscInBit      = 7;
  localparam logic [7:0]  AnaCfgMask    = 8'hcf;
  localparam logic [7:0]  InputOnlyMask = 8'h20;
  localparam logic [7:0]  AnaCapable    = 8'h1f;

  typedef struct packed {
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [AddrWidth-1:0] paddr;
    logic [DataWidth-1:0] pwdata;
    logic [3:0]           pstrb;
  } apb_req_s;

  typedef struct packed {
    logic [DataWidth-1:0] prdata;
    logic                 pready;
    logic                 pslverr;
  } apb_rsp_s;

  // Pin-ownership requests from neighbouring units, same clock domain
  typedef struct packed {
    logic timerClkSel;
    logic masterClearEn;
    logic clkOutEn;
    logic clkOutLevel;
    logic oscInClaim;
  } periph_ctl_s;
endpackage

//--- eight_bit_port_a_gpio.sv
// Eight-bit port A general-purpose I/O block with an APB register slave
`timescale 1ns/1ps
module eight_bit_port_a_gpio
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire gpio_port_pkg::apb_req_s   apbReq,
  output gpio_port_pkg::apb_rsp_s        apbRsp,
  input  wire gpio_port_pkg::periph_ctl_s periphCtl,
  input  wire logic [7:0]                padIn,
  output logic [7:0]                     padOut,
  output logic [7:0]                     padOe,
  output logic [7:0]                     analogSel,
  output logic                           timerExtClockIn,
  output logic                           masterClearInput
);
  import gpio_port_pkg::*;

  function automatic logic [7:0] regIndex(input logic [AddrWidth-1:0] addr);
    regIndex = addr[9:2];
  endfunction

  // Analog pin map per select code; unknown codes leave all pins digital
  function automatic logic [7:0] analogMap(input logic [CfgWidth-1:0] sel);
    logic [7:0] m;
    m = 8'h00;
    unique case (sel)
      4'h0, 4'h1, 4'h8: m = 8'h1f;
      4'h2, 4'h3:       m = 8'h1f;
      4'h4, 4'h5:       m = 8'h0b;
      4'h9, 4'ha:       m = 8'h0f;
      4'hb, 4'hc:       m = 8'h0f;
      4'hd:             m = 8'h0c;
      4'he:             m = 8'h01;
      default:          m = 8'h00;
    endcase
    analogMap = m & AnaCapable;
  endfunction

  // Pin synchroniser
  logic [7:0] padMeta_q;
  logic [7:0] padSync_q;

  // Registers
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] anaCfg_q;
  logic [7:0] anaCfg_d;

  // Pad and peripheral outputs
  logic [7:0] padOut_q;
  logic [7:0] padOut_d;
  logic [7:0] padOe_q;
  logic [7:0] padOe_d;
  logic [7:0] anaSel_q;
  logic [7:0] anaSel_d;
  logic       tmrClk_q;
  logic       tmrClk_d;
  logic       master_clear_input_q;
  logic       master_clear_input_d;

  // Bus response
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // Combinational views
  logic [7:0] analogMask;
  logic [7:0] claimedMask;
  logic [7:0] gpioOutMask;
  logic [7:0] pinReadVal;
  logic [7:0] dirReadVal;
  logic [7:0] idx;
  logic       accessCyc;
  logic       mapped;

  always_comb
  begin
    analogMask  = analogMap(anaCfg_q[CfgWidth-1:0]);
    claimedMask = 8'h00;
    claimedMask[TimerClkBit]  = periphCtl.timerClkSel;
    claimedMask[InputOnlyBit] = periphCtl.masterClearEn;
    claimedMask[ClkOutBit]    = periphCtl.clkOutEn;
    claimedMask[OscInBit]     = periphCtl.oscInClaim;
    // Pins read as seen on the pads, analog and claimed bits gated off
    pinReadVal  = padSync_q & ~analogMask & ~claimedMask;
    dirReadVal  = dir_q | InputOnlyMask;
    gpioOutMask = ~dir_q & ~analogMask & ~claimedMask & ~InputOnlyMask;
    idx         = regIndex(apbReq.paddr);
    accessCyc   = apbReq.psel && apbReq.penable && !pready_q;
    mapped      = (idx == PinDataIdx) || (idx == DirIdx) || (idx == AnaCfgIdx);
  end

  // Register next values
  always_comb
  begin
    latch_d  = latch_q;
    dir_d    = dir_q;
    anaCfg_d = anaCfg_q;
    if (accessCyc && apbReq.pwrite && mapped)
    begin
      unique case (idx)
        PinDataIdx:
        begin
          // Lane not strobed keeps the sampled pin levels
          latch_d = apbReq.pstrb[0] ? apbReq.pwdata[7:0] : pinReadVal;
        end
        DirIdx:
        begin
          if (apbReq.pstrb[0])
          begin
            dir_d = apbReq.pwdata[7:0];
          end
        end
        default:
        begin
          if (apbReq.pstrb[0])
          begin
            anaCfg_d = apbReq.pwdata[7:0] & AnaCfgMask;
          end
        end
      endcase
    end
  end

  // Bus answer: one wait state, response registered
  always_comb
  begin
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (accessCyc)
    begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      prdata_d  = 32'h0000_0000;
      if (!apbReq.pwrite)
      begin
        unique case (1'b1)
          idx == PinDataIdx: prdata_d[7:0] = pinReadVal;
          idx == DirIdx:     prdata_d[7:0] = dirReadVal;
          idx == AnaCfgIdx:  prdata_d[7:0] = anaCfg_q;
          default:           prdata_d[7:0] = 8'h00;
        endcase
      end
    end
  end

  // Pad drive
  always_comb
  begin
    padOe_d  = gpioOutMask;
    padOut_d = latch_q & gpioOutMask;
    if (periphCtl.clkOutEn)
    begin
      padOe_d[ClkOutBit]  = 1'b1;
      padOut_d[ClkOutBit] = periphCtl.clkOutLevel;
    end
    anaSel_d = analogMask;
    tmrClk_d = periphCtl.timerClkSel & padSync_q[TimerClkBit];
    master_clear_input_d   = periphCtl.masterClearEn & padSync_q[InputOnlyBit];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      padMeta_q <= 8'h00;
      padSync_q <= 8'h00;
      latch_q   <= LatchReset;
      dir_q     <= DirReset;
      anaCfg_q  <= AnaCfgReset;
      padOut_q  <= 8'h00;
      padOe_q   <= 8'h00;
      anaSel_q  <= AnaCapable;
      tmrClk_q  <= 1'b0;
      master_clear_input_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      padMeta_q <= padIn;
      padSync_q <= padMeta_q;
      latch_q   <= latch_d;
      dir_q     <= dir_d;
      anaCfg_q  <= anaCfg_d;
      padOut_q  <= padOut_d;
      padOe_q   <= padOe_d;
      anaSel_q  <= anaSel_d;
      tmrClk_q  <= tmrClk_d;
      master_clear_input_q    <= master_clear_input_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign apbRsp.prdata    = prdata_q;
  assign apbRsp.pready    = pready_q;
  assign apbRsp.pslverr   = pslverr_q;
  assign padOut           = padOut_q;
  assign padOe            = padOe_q;
  assign analogSel        = anaSel_q;
  assign timerExtClockIn  = tmrClk_q;
  assign masterClearInput = master_clear_input_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Antecedents skip reset edges: the edge that releases reset would
  // otherwise compare reset outputs against pre-reset state
  sequence sPortRead;
    ce && !rst && accessCyc && !apbReq.pwrite && idx == PinDataIdx;
  endsequence

  sequence sDirRead;
    ce && !rst && accessCyc && !apbReq.pwrite && idx == DirIdx;
  endsequence

  sequence sCfgRead;
    ce && !rst && accessCyc && !apbReq.pwrite && idx == AnaCfgIdx;
  endsequence

  sequence sMergeWrite;
    ce && !rst && accessCyc && apbReq.pwrite && idx == PinDataIdx && !apbReq.pstrb[0];
  endsequence

  sequence sFullWrite;
    ce && !rst && accessCyc && apbReq.pwrite && idx == PinDataIdx && apbReq.pstrb[0];
  endsequence

  sequence sDirWrite;
    ce && !rst && accessCyc && apbReq.pwrite && idx == DirIdx && apbReq.pstrb[0];
  endsequence

  sequence sUnmapped;
    ce && !rst && accessCyc && !mapped;
  endsequence

  chk_input_float: assert property (
    ce && !rst |=> (padOe_q & $past(dir_q) & ~8'h40) == 8'h00)
    else $error("input-direction pin is driven");

  chk_dir_write: assert property (
    sDirWrite |=> dir_q == $past(apbReq.pwdata[7:0]))
    else $error("direction write not stored");

  chk_output_drive: assert property (
    ce && !rst |=> ((padOut_q ^ $past(latch_q)) & $past(gpioOutMask)) == 8'h00
           && (padOe_q & $past(gpioOutMask)) == $past(gpioOutMask))
    else $error("output pin does not carry latch value");

  chk_latch_write: assert property (
    sFullWrite |=> latch_q == $past(apbReq.pwdata[7:0]))
    else $error("port write not stored in latch");

  chk_unmapped_idle: assert property (
    sUnmapped |=> pslverr_q && prdata_q == 32'h0000_0000
      && $stable(latch_q) && $stable(dir_q) && $stable(anaCfg_q))
    else $error("unmapped access changed state");

  chk_ce_freeze: assert property (
    !ce && !rst |=> $stable(latch_q) && $stable(padOut_q) && $stable(padOe_q))
    else $error("state moved while clock enable low");

  chk_analog_zero: assert property (
    sPortRead ##0 (analogMask != 8'h00)
      |=> pready_q && (prdata_q[7:0] & $past(analogMask)) == 8'h00)
    else $error("analog pin reads nonzero");

  chk_read_pins: assert property (
    sPortRead |=> pready_q && prdata_q[7:0] == $past(padSync_q & ~analogMask & ~claimedMask))
    else $error("port read is not pin levels");

  chk_rmw_merge: assert property (
    sMergeWrite |=> latch_q == $past(pinReadVal))
    else $error("unstrobed write did not store sampled pins");

  chk_bit5_input: assert property (
    !padOe_q[InputOnlyBit])
    else $error("input-only pin is driven");

  chk_dir5_one: assert property (
    sDirRead |=> prdata_q[InputOnlyBit] == 1'b1)
    else $error("direction bit five reads zero");

  chk_claim_idle: assert property (
    ce && !rst |=> (padOe_q & $past(claimedMask) & ~8'h40) == 8'h00)
    else $error("claimed pin driven by port");

  chk_claim_read: assert property (
    sPortRead |=> (prdata_q[7:0] & $past(claimedMask)) == 8'h00)
    else $error("claimed pin visible to port read");

  chk_timer_claim: assert property (
    ce && !rst && periphCtl.timerClkSel |=> !padOe_q[TimerClkBit]
      && timerExtClockIn == $past(padSync_q[TimerClkBit]))
    else $error("timer clock pin not handed over");

  chk_timer_idle: assert property (
    ce && !rst && !periphCtl.timerClkSel |=> !timerExtClockIn)
    else $error("timer clock passed while unclaimed");

  chk_master_clear_input_claim: assert property (
    ce && !rst && periphCtl.masterClearEn |=> !padOe_q[InputOnlyBit]
      && masterClearInput == $past(padSync_q[InputOnlyBit]))
    else $error("master clear pin not handed over");

  chk_master_clear_input_idle: assert property (
    ce && !rst && !periphCtl.masterClearEn |=> !masterClearInput)
    else $error("master clear passed while unclaimed");

  chk_clock_out: assert property (
    ce && !rst && periphCtl.clkOutEn |=> padOe_q[ClkOutBit]
      && padOut_q[ClkOutBit] == $past(periphCtl.clkOutLevel))
    else $error("clock out not on pin six");

  chk_osc_claim: assert property (
    ce && !rst && periphCtl.oscInClaim |=> !padOe_q[OscInBit])
    else $error("oscillator input pin is driven");

  chk_analog_float: assert property (
    ce && !rst |=> analogSel == $past(analogMask)
      && (padOe_q & $past(analogMask)) == 8'h00)
    else $error("analog pin not released to analog use");

  chk_cfg_read: assert property (
    sCfgRead |=> prdata_q[7:0] == $past(anaCfg_q))
    else $error("analog configuration reads wrong");
endmodule

//--- gpio_pad_model.sv
// Board-side pad model: resolves each pin from the port driver and the outside level
`timescale 1ns/1ps
module gpio_pad_model
(
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] extLevel,
  output logic [7:0]      padIn
);
  // Released pins show the outside level, never the last driven value
  assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule

//--- eight_bit_port_a_gpio_bench.sv
// Self-checking bench for the eight-bit general-purpose port
`timescale 1ns/1ps
module eight_bit_port_a_gpio_bench;
  import gpio_port_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce  = 1'b1;
  apb_req_s    req = '0;
  apb_rsp_s    rsp;
  periph_ctl_s pc  = '0;
  logic [7:0]  padIn, padOut, padOe, analogSel, ext;
  logic        tmrIn, mclrIn;
  logic [31:0] rdat;
  logic        rerr;
  int          err_total  = 0;
  int          num_checks = 0;
  logic [7:0]  anaMap [16] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 8'h00, 8'h00,
                               8'h1f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h0c, 8'h01, 8'h00};

  always #20 clk = ~clk;

  eight_bit_port_a_gpio dut_u (.clk(clk), .rst(rst), .ce(ce), .apbReq(req), .apbRsp(rsp),
    .periphCtl(pc), .padIn(padIn), .padOut(padOut), .padOe(padOe), .analogSel(analogSel),
    .timerExtClockIn(tmrIn), .masterClearInput(mclrIn));

  gpio_pad_model pad_u (.padOut(padOut), .padOe(padOe), .extLevel(ext), .padIn(padIn));

  task automatic close_out();
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  // Request held until the edge that ends the pready cycle
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     input logic sb);
    int n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= {2'b00, idx, 2'b00};
    req.pwdata  <= {24'h000000, wd};
    req.pstrb   <= {3'b000, sb};
    @(posedge clk);
    req.penable <= 1'b1;
    // Values read here are those sampled at this rising edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1)
    begin
      err_total++;
      close_out();
    end
    else
    begin
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reset_state();
    ext <= 8'hff;
    wt(4);
    chk(analogSel, 8'h1f);
    chk(padOe, 8'h00);
    apb(1'b0, DirIdx, 8'h00, 1'b1);
    chk(rdat, 32'h0000_00ff);
    apb(1'b0, PinDataIdx, 8'h00, 1'b1);
    chk(rdat, 32'h0000_00e0);
    apb(1'b0, 8'h40, 8'h00, 1'b1);
    chk(rdat, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
  endtask

  // Second reset in mid-run, with latch and direction already changed
  task automatic mid_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reset_state();
  endtask

  task automatic analog_codes();
    apb(1'b1, AnaCfgIdx, 8'hff, 1'b1);
    apb(1'b0, AnaCfgIdx, 8'h00, 1'b1);
    chk(rdat, 32'h0000_00cf);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, AnaCfgIdx, 8'(i), 1'b1);
      wt(2);
      chk(analogSel, anaMap[i]);
    end
    apb(1'b1, AnaCfgIdx, 8'h06, 1'b1);
  endtask

  task automatic direction_latch();
    ext <= 8'h00;
    apb(1'b1, PinDataIdx, 8'ha5, 1'b1);
    apb(1'b1, DirIdx, 8'h00, 1'b1);
    wt(4);
    chk(padOe, 8'hdf);
    chk(padOut, 8'h85);
    apb(1'b0, DirIdx, 8'h00, 1'b1);
    chk(rdat, 32'h0000_0020);
    apb(1'b1, DirIdx, 8'hff, 1'b1);
    ext <= 8'h5a;
    wt(4);
    chk(padOe, 8'h00);
    apb(1'b0, PinDataIdx, 8'h00, 1'b1);
    chk(rdat, 32'h0000_005a);
    apb(1'b1, PinDataIdx, 8'h00, 1'b0);
    apb(1'b1, DirIdx, 8'h00, 1'b1);
    wt(4);
    chk(padOut, 8'h5a);
  endtask

  task automatic peripherals();
    apb(1'b1, PinDataIdx, 8'hff, 1'b1);
    ext <= 8'h30;
    pc  <= '{timerClkSel: 1'b1, masterClearEn: 1'b1, clkOutEn: 1'b1, clkOutLevel: 1'b0,
             oscInClaim: 1'b1};
    wt(4);
    chk(padOe, 8'h4f);
    chk(padOut & 8'h40, 8'h00);
    chk({tmrIn, mclrIn}, 2'b11);
    apb(1'b0, PinDataIdx, 8'h00, 1'b1);
    chk(rdat, 32'h0000_000f);
    ext            <= 8'h00;
    pc.clkOutLevel <= 1'b1;
    wt(4);
    chk(padOut & 8'h40, 8'h40);
    chk({tmrIn, mclrIn}, 2'b00);
    // Claims dropped while frozen must not reach the pins until ce returns
    @(posedge clk);
    ce <= 1'b0;
    pc <= '0;
    wt(4);
    chk(padOe, 8'h4f);
    @(posedge clk);
    ce <= 1'b1;
    wt(4);
    chk(padOe, 8'hdf);
  endtask

  initial
  begin
    ext <= 8'hff;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reset_state();
    analog_codes();
    direction_latch();
    peripherals();
    mid_reset();
    close_out();
  end
endmodule
